// ==== src/cpr_clock_path_regs.v ====
// buffered and active control registers of the clock input and sync path
`timescale 1ns/1ps
`include "cpr_consts.vh"

// Function
// [R01] prescaler code 0..4 divides 2..6, code 6 ratio 1, 5/7 static
// [R02] clock input bypass bit chooses prescaler use or bypass
// [R03] clock input bit 4 powers down buffer, prescaler and clock tree
// [R04] system bit 3 set disables the anti-runt circuitry
// [R05] system bit 2 set powers down the sync circuitry
// [R06] system bit 1 set powers down the distribution reference
// [R07] soft sync bit high holds selected channels static, inverse of pin
// [R08] soft sync falling from one to zero triggers a sync event
// [R09] writing one to commit bit copies buffered values into active
// [R10] the copy happens on the next serial clock rising edge
// [R11] the commit bit clears itself after the copy
// [R12] direct routing only takes effect while prescaler bypass is zero
// [R13] per-channel ignore bit makes that divider disregard chip sync
// [R14] staged writes change nothing until committed; unused bits read zero
module cpr_clock_path_regs #(
   parameter NUM_CH = 4
)(
   // serial clock domain and reset
   input wire clk,
   input wire resetn,
   // register access from the serial port engine
   input wire wr_en,
   input wire rd_en,
   input wire [`CPR_ADDR_W-1:0] addr,
   input wire [7:0] wr_data,
   output reg [7:0] rd_data,
   // external sync pin, active low, and per-channel controls
   input wire sync_pin_n,
   input wire [NUM_CH-1:0] ch_direct_route,
   input wire [NUM_CH-1:0] ch_ignore_sync,
   // active prescaler controls
   output reg [2:0] prescale_ratio,
   output reg prescale_bypass,
   output reg prescale_static,
   output reg clkin_power_down,
   // active sync, reference and direct routing controls
   output reg antirunt_enable,
   output reg sync_power_down,
   output reg dist_ref_power_down,
   output reg sync_event,
   output wire [NUM_CH-1:0] ch_sync_hold,
   output wire [NUM_CH-1:0] ch_sync_release,
   output wire [NUM_CH-1:0] ch_route_direct
);

   // buffered copies that software writes
   reg [2:0] buf_prescale_q;
   reg [1:0] buf_clkin_q;
   reg [3:0] buf_system_q;
   // active copies that steer the hardware
   reg [2:0] act_prescale_q;
   reg [1:0] act_clkin_q;
   reg [3:0] act_system_q;
   reg commit_q;
   reg sync_hold_q;
   wire soft_sync;
   wire act_bypass;
   wire sync_hold_d;
   wire sync_fall;
   // address matches
   wire hit_prescale;
   wire hit_clkin;
   wire hit_system;
   wire hit_commit;
   // decoded next values of the output flops
   reg [2:0] ratio_d;
   reg static_d;

   // one address match per register, shared by staging and commit
   assign hit_prescale = wr_en && addr == `CPR_OFS_PRESCALE;
   assign hit_clkin = wr_en && addr == `CPR_OFS_CLKIN;
   assign hit_system = wr_en && addr == `CPR_OFS_SYSTEM;
   assign hit_commit = wr_en && addr == `CPR_OFS_COMMIT;

   // staging writes; active copies untouched until commit
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         buf_prescale_q <= `CPR_PRESCALE_RST;
         buf_clkin_q <= `CPR_CLKIN_RST;
         buf_system_q <= `CPR_SYSTEM_RST;
         commit_q <= 1'b0;
      end
      else
      begin
         if (hit_prescale)
            buf_prescale_q <= wr_data[2:0]; // [R14]
         // only bits 4 and 0 are kept; the rest read back zero
         if (hit_clkin)
         begin
            buf_clkin_q[1] <= wr_data[`CPR_CLKIN_PD_BIT];
            buf_clkin_q[0] <= wr_data[`CPR_CLKIN_BYPASS_BIT];
         end
         if (hit_system)
            buf_system_q <= wr_data[3:0];
         // pending flag lives one edge, then drops by itself
         commit_q <= hit_commit && wr_data[`CPR_COMMIT_BIT]; // [R11]
      end
   end

   // copy on the serial clock edge following the commit write
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         act_prescale_q <= `CPR_PRESCALE_RST;
         act_clkin_q <= `CPR_CLKIN_RST;
         act_system_q <= `CPR_SYSTEM_RST;
      end
      // a write landing with the copy waits for the next commit
      else if (commit_q)
      begin
         act_prescale_q <= buf_prescale_q; // [R09] [R10]
         act_clkin_q <= buf_clkin_q;
         act_system_q <= buf_system_q;
      end
   end

   // readback shows staged values; unused bits and commit read zero
   always @*
   begin
      rd_data = 8'h00;
      if (rd_en)
      begin
         case (addr)
            `CPR_OFS_PRESCALE: rd_data = {5'h00, buf_prescale_q}; // [R14]
            `CPR_OFS_CLKIN: rd_data = {3'h0, buf_clkin_q[1], 3'h0,
                                       buf_clkin_q[0]};
            `CPR_OFS_SYSTEM: rd_data = {4'h0, buf_system_q};
            default: rd_data = 8'h00;
         endcase
      end
   end

   // bypass from the active copy, so routing also waits for commit
   assign act_bypass = act_clkin_q[0];
   // soft bit high acts like pin low; either one holds
   // pin is used live and taken as already synchronous to clk
   assign soft_sync = act_system_q[`CPR_SYS_SOFT_SYNC_BIT];
   assign sync_hold_d = (soft_sync | ~sync_pin_n) &
                        ~act_system_q[`CPR_SYS_SYNC_PD_BIT]; // [R07]
   // powering sync down drops the hold but must not fake a release
   assign sync_fall = sync_hold_q & ~sync_hold_d &
                      ~act_system_q[`CPR_SYS_SYNC_PD_BIT]; // [R05] [R08]

   // hold state register and release pulse
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sync_hold_q <= 1'b0;
         sync_event <= 1'b0;
      end
      else
      begin
         sync_hold_q <= sync_hold_d;
         sync_event <= sync_fall; // [R08]
      end
   end

   // code to ratio; bypass wins over any code, static needs bypass off
   always @*
   begin
      ratio_d = `CPR_RATIO_STATIC;
      static_d = 1'b0;
      if (act_bypass)
         ratio_d = `CPR_RATIO_BYPASS; // [R02]
      else
      begin
         case (act_prescale_q)
            `CPR_CODE_BYPASS:
               ratio_d = `CPR_RATIO_BYPASS; // [R01]
            `CPR_CODE_STATIC_A, `CPR_CODE_STATIC_B:
               static_d = 1'b1; // [R01]
            default:
               ratio_d = act_prescale_q + `CPR_RATIO_BASE; // [R01]
         endcase
      end
   end

   // decoded active controls, registered for clean outputs
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         prescale_ratio <= `CPR_RATIO_RST;
         prescale_bypass <= 1'b0;
         prescale_static <= 1'b0;
         clkin_power_down <= 1'b0;
         antirunt_enable <= 1'b1;
         sync_power_down <= 1'b0;
         dist_ref_power_down <= 1'b0;
      end
      else
      begin
         // ratio 1 when the code or the bypass bit asks for it
         prescale_ratio <= ratio_d; // [R01] [R02]
         prescale_bypass <= act_bypass; // [R02]
         prescale_static <= static_d; // [R01]
         clkin_power_down <= act_clkin_q[1]; // [R03]
         antirunt_enable <= !act_system_q[`CPR_SYS_ANTIRUNT_BIT]; // [R04]
         sync_power_down <= act_system_q[`CPR_SYS_SYNC_PD_BIT]; // [R05]
         dist_ref_power_down <= act_system_q[`CPR_SYS_DREF_PD_BIT]; // [R06]
      end
   end

   // per-channel gating of sync and direct routing
   // ignore bits are live; changing one mid-hold frees that channel
   genvar i;
   generate
      for (i = 0; i < NUM_CH; i = i + 1)
      begin : g_ch
         assign ch_sync_hold[i] = sync_hold_q & ~ch_ignore_sync[i]; // [R13]
         assign ch_sync_release[i] = sync_event & ~ch_ignore_sync[i]; // [R13]
         assign ch_route_direct[i] = ch_direct_route[i] & ~act_bypass; // [R12]
      end
   endgenerate

endmodule

// ==== src/cpr_consts.vh ====
// register offsets, field positions and reset values for the clock path bank
`ifndef CPR_CONSTS_VH
`define CPR_CONSTS_VH
`define CPR_ADDR_W 12
`define CPR_OFS_PRESCALE 12'h1E0
`define CPR_OFS_CLKIN 12'h1E1
`define CPR_OFS_SYSTEM 12'h230
`define CPR_OFS_COMMIT 12'h232
`define CPR_PRESCALE_RST 3'h0
`define CPR_CLKIN_RST 2'h0
`define CPR_SYSTEM_RST 4'h0
`define CPR_CLKIN_BYPASS_BIT 0
`define CPR_CLKIN_PD_BIT 4
`define CPR_SYS_ANTIRUNT_BIT 3
`define CPR_SYS_SYNC_PD_BIT 2
`define CPR_SYS_DREF_PD_BIT 1
`define CPR_SYS_SOFT_SYNC_BIT 0
`define CPR_COMMIT_BIT 0
`define CPR_CODE_STATIC_A 3'h5
`define CPR_CODE_BYPASS 3'h6
`define CPR_CODE_STATIC_B 3'h7
`define CPR_RATIO_RST 3'h2
`define CPR_RATIO_BASE 3'h2
`define CPR_RATIO_BYPASS 3'h1
`define CPR_RATIO_STATIC 3'h0
`endif

// ==== tb/clock_path_sync_update_regs_test.sv ====
// self-checking bench for the clock path register bank
`timescale 1ns/1ps
module clock_path_sync_update_regs_test;
   logic clk, resetn, sync_pin_n, wr_en, rd_en, prescale_bypass, sync_event;
   logic [11:0] addr;
   logic [7:0] wr_data, rd_data, d;
   logic [3:0] ch_direct_route, ch_ignore_sync, ch_sync_hold;
   logic [3:0] ch_sync_release, ch_route_direct;
   logic [2:0] prescale_ratio, prev;
   logic prescale_static, clkin_power_down, antirunt_enable;
   logic sync_power_down, dist_ref_power_down;
   int fail_count, tests_run;
   cpr_host_model host_u (.clk, .wr_en, .rd_en, .addr, .wr_data, .rd_data);
   cpr_clock_path_regs dut_u (.clk, .resetn, .wr_en, .rd_en, .addr, .wr_data,
      .rd_data, .sync_pin_n, .ch_direct_route, .ch_ignore_sync,
      .prescale_ratio, .prescale_bypass, .prescale_static, .clkin_power_down,
      .antirunt_enable, .sync_power_down, .dist_ref_power_down, .sync_event,
      .ch_sync_hold, .ch_sync_release, .ch_route_direct);
   // 100 MHz clock
   initial
   begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   task ck(input [7:0] g, input [7:0] e);
      tests_run++;
      if (g !== e)
      begin
         fail_count++;
         $display("Error %0t: got %h want %h", $time, g, e);
      end
   endtask
   // commit, then wait out the two-edge latency
   task cm;
      host_u.commit;
      repeat (2) @(posedge clk);
      #1;
   endtask
   // every prescaler code, staged value invisible until committed
   task t_codes;
      prev = 3'h2;
      for (int c = 0; c < 8; c++)
      begin
         host_u.wr(12'h1E0, 8'hF8 | c[7:0]);
         host_u.rd(12'h1E0, d);
         ck(d, c[7:0]);
         ck(prescale_ratio, prev);
         cm;
         prev = 3'(c < 5 ? c + 2 : c == 6);
         ck(prescale_ratio, prev);
         ck(prescale_static, c == 5 || c == 7);
      end
   endtask
   // bypass overrides code and blocks direct routing; input power-down
   task t_clkin;
      @(posedge clk) ch_direct_route <= 4'hF;
      host_u.wr(12'h1E1, 8'h11);
      cm;
      ck(prescale_ratio, 8'h01);
      ck(prescale_bypass, 8'h01);
      ck(prescale_static, 8'h00);
      ck(ch_route_direct, 8'h00);
      ck(clkin_power_down, 8'h01);
      host_u.wr(12'h1E1, 8'h00);
      cm;
      ck(ch_route_direct, 8'h0F);
      ck(prescale_bypass, 8'h00);
      ck(prescale_static, 8'h01);
      ck(clkin_power_down, 8'h00);
   endtask
   // system bits, soft sync hold and release with two channels ignoring
   task t_sys;
      @(posedge clk) ch_ignore_sync <= 4'h3;
      host_u.wr(12'h230, 8'h0E);
      cm;
      ck(antirunt_enable, 8'h00);
      ck(sync_power_down, 8'h01);
      ck(dist_ref_power_down, 8'h01);
      host_u.wr(12'h230, 8'h05);
      cm;
      ck(ch_sync_hold, 8'h00);
      host_u.wr(12'h230, 8'h01);
      cm;
      ck(ch_sync_hold, 8'h0C);
      host_u.wr(12'h230, 8'h00);
      cm;
      ck(sync_event, 8'h01);
      ck(ch_sync_release, 8'h0C);
      // pin low holds like the soft bit, its rise releases
      @(posedge clk) sync_pin_n <= 1'h0;
      @(posedge clk);
      #1;
      ck(ch_sync_hold, 8'h0C);
      @(posedge clk) sync_pin_n <= 1'h1;
      @(posedge clk);
      #1;
      ck(ch_sync_release, 8'h0C);
      host_u.rd(12'h232, d);
      ck(d, 8'h00);
   endtask
   // defaults right after reset release
   task t_reset;
      ck({prescale_ratio, antirunt_enable, clkin_power_down}, 8'h0A);
      ck(prescale_bypass, 8'h00);
      ck(sync_power_down, 8'h00);
      ck(dist_ref_power_down, 8'h00);
      ck(sync_event, 8'h00);
   endtask
   task end_sim;
      $display("checks %0d errors %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // reset, defaults, scenarios; guard cuts a hang short
   initial
   begin
      {resetn, sync_pin_n, ch_direct_route, ch_ignore_sync} = 10'h100;
      repeat (3) @(posedge clk);
      resetn <= 1'h1;
      @(posedge clk);
      #1;
      fork
         begin
            t_reset;
            t_codes;
            t_clkin;
            t_sys;
         end
         begin
            // a hang runs out this bound and counts as a failure
            repeat (3000) @(posedge clk);
            fail_count++;
         end
      join_any
      end_sim;
   end
endmodule

// ==== tb/cpr_checker.sv ====
// port assertions for the clock path register bank
`timescale 1ns/1ps
module cpr_checker (
   // clock, reset and register access
   input wire clk,
   input wire resetn,
   input wire wr_en,
   input wire rd_en,
   input wire [11:0] addr,
   input wire [7:0] wr_data,
   input wire [7:0] rd_data,
   // active prescaler and sync outputs
   input wire [2:0] prescale_ratio,
   input wire prescale_bypass,
   input wire prescale_static,
   input wire sync_event
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // commit request as the bank takes it
   wire cw = wr_en && addr == 12'h232 && wr_data[0];
   // no commit three edges back: the output flops cannot have moved
   sequence s_no_commit; !cw ##3 1; endsequence
   a_staged_hold: assert property
      (s_no_commit |-> $stable(prescale_ratio))
      else $error("ratio moved");
   a_event_pulse: assert property
      (sync_event |=> !sync_event)
      else $error("long pulse");
   a_static_zero: assert property
      (prescale_static |-> !prescale_ratio)
      else $error("static ratio");
   a_bypass_one: assert property
      (prescale_bypass |-> prescale_ratio == 3'h1)
      else $error("bypass ratio");
   a_ratio_range: assert property
      (!prescale_static |-> prescale_ratio inside {[1:6]})
      else $error("range");
   a_commit_reads: assert property
      (rd_en && addr == 12'h232 |-> !rd_data)
      else $error("commit read");
   a_unused_zero: assert property
      (rd_en && addr == 12'h1E0 |-> !rd_data[7:3])
      else $error("unused bits");
   a_reads_idle: assert property
      (!rd_en |-> rd_data == 8'h00)
      else $error("idle read");
endmodule
bind cpr_clock_path_regs cpr_checker chk_u (.clk, .resetn, .wr_en, .rd_en,
   .addr, .wr_data, .rd_data, .prescale_ratio, .prescale_bypass,
   .prescale_static, .sync_event);

// ==== tb/cpr_host_model.sv ====
// host controller model issuing single-byte register accesses
`timescale 1ns/1ps
module cpr_host_model (
   // bus clock
   input wire clk,
   // register access toward the bank
   output logic wr_en,
   output logic rd_en,
   output logic [11:0] addr,
   output logic [7:0] wr_data,
   input wire [7:0] rd_data
);
   // bus idle from time zero
   initial {wr_en, rd_en, addr, wr_data} = 22'h0;
   // strobe for one taking edge; data scrambled after so nothing stale
   task wr(input [11:0] a, input [7:0] d);
      @(posedge clk);
      {wr_en, addr, wr_data} <= {1'h1, a, d};
      @(posedge clk);
      {wr_en, wr_data} <= {1'h0, ~d};
   endtask
   // enable held one cycle, data taken at the closing edge
   task rd(input [11:0] a, output [7:0] d);
      @(posedge clk);
      {rd_en, addr} <= {1'h1, a};
      @(posedge clk);
      d = rd_data;
      rd_en <= 1'h0;
   endtask
   // staged settings only act after this write
   task commit;
      wr(12'h232, 8'h01);
   endtask
endmodule
